// File: design/pao_defines.svh
// Register map, field positions, reset values and bus codes for port override
`ifndef PAO_DEFINES_SVH
`define PAO_DEFINES_SVH

// Register byte offsets on the AXI4-Lite slave
`define PAO_OFS_DIR        8'h00
`define PAO_OFS_OUT        8'h04
`define PAO_OFS_PIN        8'h08
`define PAO_OFS_MCU        8'h0C
`define PAO_OFS_PINCHG     8'h10

// Field positions in mcu_control
`define PAO_MCU_VCU_BIT    0
`define PAO_MCU_VTS_BIT    1
`define PAO_MCU_KILL_BIT   4
`define PAO_MCU_RW_MASK    8'h13

// Reset values
`define PAO_DIR_RST        8'h00
`define PAO_OUT_RST        8'h00
`define PAO_MCU_RST        8'h00

// Pin positions with fixed alternate roles
`define PAO_PIN_CLKOUT     0
`define PAO_PIN_OSC_IN     6
`define PAO_PIN_OSC_OUT    7

// AXI response codes
`define PAO_RESP_OKAY      2'h0
`define PAO_RESP_SLVERR    2'h2

`endif

// File: design/pao_pkg.sv
// Types shared by the port override block
package pao_pkg;

	typedef logic [7:0] pao_byte_t;

	// One-hot register selector from the address decoder
	typedef enum logic [5:0] {
		PAO_REG_NONE   = 6'h01,
		PAO_REG_DIR    = 6'h02,
		PAO_REG_OUT    = 6'h04,
		PAO_REG_PIN    = 6'h08,
		PAO_REG_MCU    = 6'h10,
		PAO_REG_PINCHG = 6'h20
	} pao_reg_t;

endpackage

// File: design/pao_port_override.sv
// Port B pin control with alternate-function overrides and AXI4-Lite registers
//
// Notes on behaviour
// R1: Without pull-up override, pull-up on only when dir, out, kill are 0,1,0.
// R2: With pull-up override enabled, pull-up follows its override value alone.
// R3: Without driver override, output driver enable is the pin's direction bit.
// R4: With driver override enabled, driver enable follows its override value.
// R5: Value override enabled and driver on: pin drives the override value.
// R6: Value override disabled and driver on: pin drives its output bit.
// R7: Toggle override asserted inverts the pin's output register bit.
// R8: Input gate follows its override value when enabled, else awake state.
// R9: Peripherals synchronise the raw pin tap themselves unless used as clock.
// R10: Strobes shared per port; clock, sleep, kill shared; overrides per pin.
// R11: mcu_control is 8 bits, bits 4,1,0 read-write, others zero, resets zero.
// R12: Global pull-up kill set turns off every pull-up not under override.
// R13: Async timer clock without external clock makes bit 7 oscillator output.
// R14: Async timer clock makes bit 6 oscillator input, no general I/O.
// R15: Bit 7 as clock pin reads zero in direction, output and input bits.
// R16: Bit 6 as clock pin reads zero in direction, output and input bits.
// R17: Timer oscillator takeover only with internal RC clock and async timer.
// R18: Bit 6 is chip clock pin for every source but internal RC.
// R19: Bits 5..0 carry SPI, compare, capture and divided clock alternates.
// R20: Each port bit n feeds pin-change source n.
// R21: No override: direction one makes output, zero makes input.
// R22: Divided clock drives bit 0 when its fuse is set, and during reset.
// R23: Override muxing is combinational, no added clock cycle.
`timescale 1ns/1ps
`default_nettype none
`include "pao_defines.svh"

module pao_port_override
	import pao_pkg::*;
#(
	parameter int PINS = 8
) (
	// Clock and reset
	input  wire logic            clk,
	input  wire logic            resetn,
	// AXI4-Lite write address
	input  wire logic [7:0]      awaddr,
	input  wire logic            awvalid,
	output logic                 awready,
	// AXI4-Lite write data
	input  wire logic [31:0]     wdata,
	input  wire logic [3:0]      wstrb,
	input  wire logic            wvalid,
	output logic                 wready,
	// AXI4-Lite write response
	output logic [1:0]           bresp,
	output logic                 bvalid,
	input  wire logic            bready,
	// AXI4-Lite read address
	input  wire logic [7:0]      araddr,
	input  wire logic            arvalid,
	output logic                 arready,
	// AXI4-Lite read data
	output logic [31:0]          rdata,
	output logic [1:0]           rresp,
	output logic                 rvalid,
	input  wire logic            rready,
	// Per-pin override signals from peripherals
	input  wire logic [PINS-1:0] pullupOverrideEn,
	input  wire logic [PINS-1:0] pullupOverrideVal,
	input  wire logic [PINS-1:0] driverOverrideEn,
	input  wire logic [PINS-1:0] driverOverrideVal,
	input  wire logic [PINS-1:0] outvalOverrideEn,
	input  wire logic [PINS-1:0] outvalOverrideVal,
	input  wire logic [PINS-1:0] toggleOverrideEn,
	input  wire logic [PINS-1:0] inputGateOverrideEn,
	input  wire logic [PINS-1:0] inputGateOverrideVal,
	// Chip-wide state
	input  wire logic            sleep,
	input  wire logic            intRcClockSel,
	input  wire logic            extClockSel,
	input  wire logic            asyncTimerClockSel,
	input  wire logic            clockOutFuse,
	input  wire logic            dividedClock,
	// Pads
	input  wire logic [PINS-1:0] padIn,
	output logic      [PINS-1:0] padOut,
	output logic      [PINS-1:0] padOe,
	output logic      [PINS-1:0] padPullup,
	output logic      [PINS-1:0] analogPadLink,
	// Towards peripherals
	output logic      [PINS-1:0] rawPinInputTap,
	output logic      [PINS-1:0] pinChangeSrc,
	output logic                 vectorTableSelect,
	output logic                 vectorChangeUnlock,
	output logic                 globalPullupKill
);

	// Reset release through two flip-flops
	logic rstnMeta_q;
	logic rstn_q;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rstnMeta_q <= 1'b0;
			rstn_q     <= 1'b0;
		end else begin
			rstnMeta_q <= 1'b1;
			rstn_q     <= rstnMeta_q;
		end
	end

	// Register decode, used by both the read and the write path
	function automatic pao_reg_t decodeReg(input logic [7:0] addr);
		unique case (addr)
			`PAO_OFS_DIR:    decodeReg = PAO_REG_DIR;
			`PAO_OFS_OUT:    decodeReg = PAO_REG_OUT;
			`PAO_OFS_PIN:    decodeReg = PAO_REG_PIN;
			`PAO_OFS_MCU:    decodeReg = PAO_REG_MCU;
			`PAO_OFS_PINCHG: decodeReg = PAO_REG_PINCHG;
			default:         decodeReg = PAO_REG_NONE;
		endcase
	endfunction

	// Port registers
	pao_byte_t pinDir_q;
	pao_byte_t pinOut_q;
	pao_byte_t mcuControl_q;

	// Clock-pin takeover of bits 6 and 7
	wire timerOscOn = intRcClockSel & asyncTimerClockSel;        // R17
	wire osc7Timer  = timerOscOn & ~extClockSel;                 // R13
	wire osc7Chip   = ~intRcClockSel & ~extClockSel;
	wire osc7Clock  = osc7Timer | osc7Chip;
	wire osc6Clock  = timerOscOn | ~intRcClockSel;               // R14 R18
	wire clkOutOn   = clockOutFuse | ~rstn_q;                    // R22

	logic [PINS-1:0] clockPin;
	always_comb begin
		clockPin = '0;
		clockPin[`PAO_PIN_OSC_IN]  = osc6Clock;
		clockPin[`PAO_PIN_OSC_OUT] = osc7Clock;
	end

	assign globalPullupKill   = mcuControl_q[`PAO_MCU_KILL_BIT];   // R10
	assign vectorTableSelect  = mcuControl_q[`PAO_MCU_VTS_BIT];
	assign vectorChangeUnlock = mcuControl_q[`PAO_MCU_VCU_BIT];
	assign analogPadLink      = clockPin;

	// Per-pin override muxing; overrides are separate per pin
	logic [PINS-1:0] inputGate;
	logic [PINS-1:0] pinMeta_q;
	logic [PINS-1:0] pinSync_q;

	genvar n;
	generate
		for (n = 0; n < PINS; n++) begin : gPin
			wire outBit   = pinOut_q[n] ^ toggleOverrideEn[n];  // R7
			wire plainPu  = ~pinDir_q[n] & outBit
				& ~globalPullupKill;                          // R1 R12
			wire puSel    = pullupOverrideEn[n] ?
				pullupOverrideVal[n] : plainPu;               // R2
			wire drvSel   = driverOverrideEn[n] ?
				driverOverrideVal[n] : pinDir_q[n];           // R3 R4 R21
			wire valSel   = outvalOverrideEn[n] ?
				outvalOverrideVal[n] : outBit;                // R5 R6
			wire gateSel  = inputGateOverrideEn[n] ?
				inputGateOverrideVal[n] : ~sleep;             // R8
			if (n == `PAO_PIN_CLKOUT) begin : gClkOut
				assign padOe[n]  = clkOutOn | drvSel;         // R22
				assign padOut[n] = clkOutOn ? dividedClock
					: (valSel & drvSel);                      // R19
				assign padPullup[n] = ~clkOutOn & puSel;
				assign inputGate[n] = gateSel;
			end else begin : gNormal
				// Clock pins are cut from the port entirely
				assign padOe[n]     = ~clockPin[n] & drvSel;   // R13 R14 R23
				assign padOut[n]    = ~clockPin[n] & drvSel & valSel;
				assign padPullup[n] = ~clockPin[n] & puSel;
				assign inputGate[n] = ~clockPin[n] & gateSel;
			end
		end
	endgenerate

	// Raw tap is gated but unsynchronised; consumers add their own stages
	assign rawPinInputTap = padIn & inputGate;                        // R9

	always_ff @(posedge clk or negedge rstn_q) begin
		if (!rstn_q) begin
			pinMeta_q <= '0;
			pinSync_q <= '0;
		end else begin
			pinMeta_q <= rawPinInputTap;
			pinSync_q <= pinMeta_q;
		end
	end

	assign pinChangeSrc = pinSync_q;                                  // R20

	// AXI4-Lite write channel: address and data taken in either order
	logic       awHeld_q;
	logic       wHeld_q;
	logic [7:0] awAddr_q;
	logic [7:0] wData_q;
	logic       wLane_q;
	logic       bValid_q;
	logic [1:0] bResp_q;

	assign awready = ~awHeld_q & ~bValid_q;
	assign wready  = ~wHeld_q & ~bValid_q;
	assign bvalid  = bValid_q;
	assign bresp   = bResp_q;

	wire awTake  = awvalid & awready;
	wire wTake   = wvalid & wready;
	wire addrRdy = awHeld_q | awTake;
	wire dataRdy = wHeld_q | wTake;
	wire doWrite = addrRdy & dataRdy & ~bValid_q;

	wire [7:0] wrAddr = awHeld_q ? awAddr_q : awaddr;
	wire [7:0] wrData = wHeld_q ? wData_q : wdata[7:0];
	wire       wrLane = wHeld_q ? wLane_q : wstrb[0];
	wire pao_reg_t wrSel = decodeReg(wrAddr);
	wire       wrHit  = doWrite & wrLane;
	wire       wrBad  = (wrSel == PAO_REG_NONE);

	always_ff @(posedge clk or negedge rstn_q) begin
		if (!rstn_q) begin
			awHeld_q <= 1'b0;
			awAddr_q <= 8'h00;
		end else if (doWrite) begin
			awHeld_q <= 1'b0;
		end else if (awTake) begin
			awHeld_q <= 1'b1;
			awAddr_q <= awaddr;
		end
	end

	always_ff @(posedge clk or negedge rstn_q) begin
		if (!rstn_q) begin
			wHeld_q <= 1'b0;
			wData_q <= 8'h00;
			wLane_q <= 1'b0;
		end else if (doWrite) begin
			wHeld_q <= 1'b0;
		end else if (wTake) begin
			wHeld_q <= 1'b1;
			wData_q <= wdata[7:0];
			wLane_q <= wstrb[0];
		end
	end

	always_ff @(posedge clk or negedge rstn_q) begin
		if (!rstn_q) begin
			bValid_q <= 1'b0;
			bResp_q  <= `PAO_RESP_OKAY;
		end else if (doWrite) begin
			bValid_q <= 1'b1;
			bResp_q  <= wrBad ? `PAO_RESP_SLVERR : `PAO_RESP_OKAY;
		end else if (bready) begin
			bValid_q <= 1'b0;
		end
	end

	// Register updates; a one written to the input register toggles output
	wire wrDir = wrHit & (wrSel == PAO_REG_DIR);
	wire wrOut = wrHit & (wrSel == PAO_REG_OUT);
	wire wrPin = wrHit & (wrSel == PAO_REG_PIN);
	wire wrMcu = wrHit & (wrSel == PAO_REG_MCU);

	always_ff @(posedge clk or negedge rstn_q) begin
		if (!rstn_q) begin
			pinDir_q <= `PAO_DIR_RST;
			pinOut_q <= `PAO_OUT_RST;
		end else begin
			if (wrDir)
				pinDir_q <= wrData;
			if (wrOut)
				pinOut_q <= wrData;
			else if (wrPin)
				pinOut_q <= pinOut_q ^ wrData;
		end
	end

	always_ff @(posedge clk or negedge rstn_q) begin
		if (!rstn_q)
			mcuControl_q <= `PAO_MCU_RST;                             // R11
		else if (wrMcu)
			mcuControl_q <= wrData & `PAO_MCU_RW_MASK;                // R11
	end

	// Read view: clock pins read zero in all three registers
	wire [PINS-1:0] readMask = ~clockPin;                             // R15 R16
	wire pao_byte_t dirView  = pinDir_q & readMask;
	wire pao_byte_t outView  = pinOut_q & readMask;
	wire pao_byte_t pinView  = pinSync_q & readMask;
	wire pao_byte_t chgView  = pinSync_q;

	// AXI4-Lite read channel: one read at a time, answer one cycle later
	logic        rValid_q;
	logic [31:0] rData_q;
	logic [1:0]  rResp_q;

	assign arready = ~rValid_q;
	assign rvalid  = rValid_q;
	assign rdata   = rData_q;
	assign rresp   = rResp_q;

	wire      arTake = arvalid & arready;
	wire pao_reg_t rdSel = decodeReg(araddr);

	pao_byte_t rdByte;
	always_comb begin
		unique case (rdSel)
			PAO_REG_DIR:    rdByte = dirView;
			PAO_REG_OUT:    rdByte = outView;
			PAO_REG_PIN:    rdByte = pinView;
			PAO_REG_MCU:    rdByte = mcuControl_q;
			PAO_REG_PINCHG: rdByte = chgView;
			default:        rdByte = 8'h00;
		endcase
	end

	always_ff @(posedge clk or negedge rstn_q) begin
		if (!rstn_q) begin
			rValid_q <= 1'b0;
			rData_q  <= 32'h0000_0000;
			rResp_q  <= `PAO_RESP_OKAY;
		end else if (arTake) begin
			rValid_q <= 1'b1;
			rData_q  <= {24'h00_0000, rdByte};
			rResp_q  <= (rdSel == PAO_REG_NONE) ?
				`PAO_RESP_SLVERR : `PAO_RESP_OKAY;
		end else if (rready) begin
			rValid_q <= 1'b0;
		end
	end

endmodule // pao_port_override

`default_nettype wire

// File: verification/pao_port_override_assertions.sv
// Concurrent checks on pin overrides, oscillator takeover and bus answers
`timescale 1ns/1ps
`default_nettype none
module pao_port_override_assertions #(
	parameter int PINS = 8
) (
	// Clock and reset
	input wire logic            clk,
	input wire logic            resetn,
	// Chip state
	input wire logic            sleep,
	input wire logic            intRcClockSel,
	input wire logic            extClockSel,
	input wire logic            asyncTimerClockSel,
	input wire logic            clockOutFuse,
	input wire logic            dividedClock,
	// Overrides
	input wire logic [PINS-1:0] pullupOverrideEn,
	input wire logic [PINS-1:0] pullupOverrideVal,
	input wire logic [PINS-1:0] driverOverrideEn,
	input wire logic [PINS-1:0] driverOverrideVal,
	input wire logic [PINS-1:0] outvalOverrideEn,
	input wire logic [PINS-1:0] outvalOverrideVal,
	input wire logic [PINS-1:0] inputGateOverrideEn,
	input wire logic [PINS-1:0] inputGateOverrideVal,
	// Pads and taps
	input wire logic [PINS-1:0] padIn,
	input wire logic [PINS-1:0] padOut,
	input wire logic [PINS-1:0] padOe,
	input wire logic [PINS-1:0] padPullup,
	input wire logic [PINS-1:0] analogPadLink,
	input wire logic [PINS-1:0] rawPinInputTap,
	input wire logic [PINS-1:0] pinChangeSrc,
	input wire logic            globalPullupKill,
	// Bus answers
	input wire logic            bvalid,
	input wire logic            bready,
	input wire logic            rvalid,
	input wire logic            rready
);
	logic [PINS-1:0] gateEn;
	logic [PINS-1:0] gated;
	logic [1:0]      oscPin;
	logic [2:0]      upCnt_q;

	assign gateEn = (inputGateOverrideEn & inputGateOverrideVal)
		| (~inputGateOverrideEn & {PINS{!sleep}});
	assign gated = padIn & gateEn;
	assign oscPin[1] = !extClockSel & (!intRcClockSel | asyncTimerClockSel);
	assign oscPin[0] = !intRcClockSel | asyncTimerClockSel;

	// Synchronisers hold zero through the internal reset stretch
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			upCnt_q <= 3'h0;
		else if (upCnt_q != 3'h7)
			upCnt_q <= upCnt_q + 3'h1;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	AST_PU_OVR: assert property (
		((padPullup ^ pullupOverrideVal) & pullupOverrideEn & 8'h3E) == 8'h00)
		else $error("pull-up ignores its override value");
	AST_PU_KILL: assert property (
		globalPullupKill |-> (padPullup & ~pullupOverrideEn & 8'h3E) == 8'h00)
		else $error("pull-up on while globally killed");
	AST_DRV_OVR: assert property (
		((padOe ^ driverOverrideVal) & driverOverrideEn & 8'h3E) == 8'h00)
		else $error("driver enable ignores its override value");
	AST_VAL_OVR: assert property (
		((padOut ^ outvalOverrideVal) & outvalOverrideEn & padOe & 8'h3E)
		== 8'h00)
		else $error("driven value ignores its override value");
	AST_GATE: assert property (
		((rawPinInputTap ^ gated) & 8'h3F) == 8'h00)
		else $error("raw tap does not follow the input gate");
	AST_OSC: assert property (
		analogPadLink[7:6] == oscPin && (padOe[7:6] & oscPin) == 2'h0
		&& (padPullup[7:6] & oscPin) == 2'h0)
		else $error("oscillator pins not released from the port");
	AST_CLKOUT: assert property (
		clockOutFuse |-> padOe[0] && padOut[0] == dividedClock)
		else $error("divided clock missing on bit 0");
	AST_PINCHG: assert property (
		upCnt_q == 3'h7 |-> (pinChangeSrc & 8'h3F) == ($past(gated, 2) & 8'h3F))
		else $error("pin-change source is not the gated pad two edges back");
	AST_BDONE: assert property (
		bvalid && bready |=> !bvalid)
		else $error("write response not retired");
	AST_RDONE: assert property (
		rvalid && rready |=> !rvalid)
		else $error("read data not retired");

	cover property (oscPin[0] && analogPadLink[6]);
	cover property (|(pullupOverrideEn & padPullup));
	cover property (bvalid && bready);
endmodule // pao_port_override_assertions

bind pao_port_override pao_port_override_assertions #(.PINS(PINS))
	i_pao_port_override_assertions (.*);
`default_nettype wire

// File: verification/pao_periph_model.sv
// Peripheral side: drives per-pin overrides and resynchronises the raw tap
`timescale 1ns/1ps
`default_nettype none
module pao_periph_model (
	// Clock and bench command
	input wire logic        clk,
	input wire logic [71:0] cmd,
	// Raw pad tap from the port
	input wire logic [7:0]  rawPinInputTap,
	// Per-pin overrides
	output logic [7:0]      pullupOverrideEn,
	output logic [7:0]      pullupOverrideVal,
	output logic [7:0]      driverOverrideEn,
	output logic [7:0]      driverOverrideVal,
	output logic [7:0]      outvalOverrideEn,
	output logic [7:0]      outvalOverrideVal,
	output logic [7:0]      toggleOverrideEn,
	output logic [7:0]      inputGateOverrideEn,
	output logic [7:0]      inputGateOverrideVal,
	// Tap after our own synchroniser
	output logic [7:0]      syncTap
);
	logic [7:0] tapMeta_q;

	always_ff @(posedge clk) begin
		{pullupOverrideEn, pullupOverrideVal, driverOverrideEn,
			driverOverrideVal, outvalOverrideEn, outvalOverrideVal,
			toggleOverrideEn, inputGateOverrideEn,
			inputGateOverrideVal} <= cmd;
		// Tap is asynchronous to us, two flops before use
		tapMeta_q <= rawPinInputTap;
		syncTap <= tapMeta_q;
	end
endmodule // pao_periph_model
`default_nettype wire

// File: verification/tb.sv
// Self-checking bench for the port override block
`timescale 1ns/1ps
`include "pao_defines.svh"
`default_nettype none
module tb;
	logic clk = 1'h0, resetn = 1'h0, sleep = 1'h0, clockOutFuse = 1'h0;
	logic intRcClockSel = 1'h1, extClockSel = 1'h0, asyncTimerClockSel = 1'h0;
	logic dividedClock = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
	logic arvalid = 1'h0, rready = 1'h0, awready, wready, bvalid, arready;
	logic rvalid, vectorTableSelect, vectorChangeUnlock, globalPullupKill;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, padIn = 8'h00, rd;
	logic [7:0] padOut, padOe, padPullup, analogPadLink, rawPinInputTap;
	logic [7:0] pinChangeSrc, syncTap, pullupOverrideEn, pullupOverrideVal;
	logic [7:0] driverOverrideEn, driverOverrideVal, outvalOverrideEn;
	logic [7:0] outvalOverrideVal, toggleOverrideEn, inputGateOverrideEn;
	logic [7:0] inputGateOverrideVal;
	logic [31:0] wdata = 32'h0, rdata;
	logic [71:0] cmd = 72'h0;
	logic [3:0] wstrb = 4'h0;
	logic [1:0] bresp, rresp, rs;
	int failures = 0, compares = 0;

	pao_port_override i_pao_port_override (.*);
	pao_periph_model i_pao_periph_model (.*);

	always #5 clk = ~clk;
	always @(posedge clk) dividedClock <= ~dividedClock;

	task automatic chk(input string n, input logic [7:0] e, g);
		compares++;
		if (g !== e) begin
			failures++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic settle;
		repeat (3) @(posedge clk);
		#1;
	endtask
	task automatic ov(input logic [71:0] c);
		@(posedge clk);
		cmd <= c;
		settle;
	endtask
	task automatic wr(input logic [7:0] a, d);
		@(posedge clk);
		awaddr <= a;
		wdata <= {24'h0, d};
		wstrb <= 4'hF;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
		end while (!bvalid);
		rs = bresp;
		bready <= 1'h0;
	endtask
	task automatic rdr(input logic [7:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'h0;
		end while (!rvalid);
		rd = rdata[7:0];
		rs = rresp;
		rready <= 1'h0;
	endtask

	task automatic t_regs;
		rdr(`PAO_OFS_MCU);
		chk("mcu reset", `PAO_MCU_RST, rd);
		wr(`PAO_OFS_MCU, 8'hFF);
		chk("bresp ok", {6'h0, `PAO_RESP_OKAY}, {6'h0, rs});
		rdr(`PAO_OFS_MCU);
		chk("rresp ok", {6'h0, `PAO_RESP_OKAY}, {6'h0, rs});
		chk("mcu bits", `PAO_MCU_RW_MASK, rd);
		chk("kill", 8'h01, {7'h0, globalPullupKill});
		chk("vec", 8'h03, 8'({vectorTableSelect, vectorChangeUnlock}));
		wr(8'h40, 8'hFF);
		chk("bresp", {6'h0, `PAO_RESP_SLVERR}, {6'h0, rs});
		rdr(8'h40);
		chk("rresp", {6'h0, `PAO_RESP_SLVERR}, {6'h0, rs});
		wr(`PAO_OFS_MCU, 8'h00);
	endtask
	task automatic t_pull;
		wr(`PAO_OFS_OUT, 8'hFF);
		wr(`PAO_OFS_DIR, 8'hF0);
		settle;
		chk("pullup", 8'h0F, padPullup);
		chk("oe", 8'hF0, padOe);
		chk("drive", 8'hF0, padOut & padOe);
		wr(`PAO_OFS_MCU, 8'h10);
		settle;
		chk("killed", 8'h00, padPullup);
		ov({8'h0F, 8'h05, 56'h0});
		chk("pullup ovr", 8'h05, padPullup);
		wr(`PAO_OFS_MCU, 8'h00);
	endtask
	task automatic t_drv;
		ov({16'h0, 8'hFF, 8'h3C, 8'h0F, 8'h0A, 8'h30, 16'h0});
		chk("oe ovr", 8'h3C, padOe);
		chk("value ovr", 8'h08, padOut & padOe);
	endtask
	task automatic t_gate;
		@(posedge clk);
		padIn <= 8'hA5;
		sleep <= 1'h1;
		ov({56'h0, 8'h03, 8'h01});
		chk("tap asleep", 8'h01, rawPinInputTap);
		@(posedge clk);
		sleep <= 1'h0;
		settle;
		chk("tap awake", 8'hA5, rawPinInputTap);
		chk("pin change", 8'hA5, pinChangeSrc);
		chk("periph tap", 8'hA5, syncTap);
		rdr(`PAO_OFS_PIN);
		chk("pin reg", 8'hA5, rd);
		rdr(`PAO_OFS_PINCHG);
		chk("pin change reg", 8'hA5, rd);
		wr(`PAO_OFS_PIN, 8'h0F);
		rdr(`PAO_OFS_OUT);
		chk("pin toggle", 8'hF0, rd);
		wr(`PAO_OFS_PIN, 8'h0F);
		rdr(`PAO_OFS_OUT);
		chk("pin toggle back", 8'hFF, rd);
	endtask
	task automatic t_osc;
		logic [1:0] e;
		wr(`PAO_OFS_DIR, 8'hFF);
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			{intRcClockSel, extClockSel, asyncTimerClockSel} <= i[2:0];
			padIn <= 8'hFF;
			settle;
			e = {!i[1] & (!i[2] | i[0]), !i[2] | i[0]};
			chk("osc link", {6'h0, e}, {6'h0, analogPadLink[7:6]});
			chk("osc oe", {~e, 6'h3F}, padOe);
			rdr(`PAO_OFS_DIR);
			chk("osc dir", {~e, 6'h3F}, rd);
			rdr(`PAO_OFS_OUT);
			chk("osc out", {~e, 6'h3F}, rd);
			rdr(`PAO_OFS_PIN);
			chk("osc pin", {~e, 6'h3D}, rd);
		end
		@(posedge clk);
		{intRcClockSel, extClockSel, asyncTimerClockSel} <= 3'h4;
	endtask
	task automatic t_divided_clock_out;
		wr(`PAO_OFS_DIR, 8'h00);
		@(posedge clk);
		clockOutFuse <= 1'h1;
		repeat (2) begin
			settle;
			chk("clk out", {7'h0, dividedClock}, {7'h0, padOut[0]});
			chk("clk oe", 8'h01, padOe);
		end
	endtask

	task automatic close_out;
		$display("Compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		repeat (3) @(posedge clk);
		#1;
		chk("reset oe", 8'h01, padOe);
		@(posedge clk);
		resetn <= 1'h1;
		repeat (3) @(posedge clk);
		t_regs;
		t_pull;
		t_drv;
		t_gate;
		t_osc;
		t_divided_clock_out;
		close_out;
	end
	initial begin
		#100000;
		failures++;
		close_out;
	end
endmodule // tb
`default_nettype wire
